// file: verilog/cmpctl_top.sv
/*
 * comparator control and interrupt block: wishbone register slave, power
 * and reference controls for the analog macro, output mirror, pin routing,
 * edge event flag and a maskable level interrupt.
 * assumes cmp_out_i is already synchronous to clk_i and the analog macro
 * reads its controls as static levels.
 */
// The implementer's own choice: the Wishbone slave port.
// Summary of operation
// - event flag sets on rising output edge, or falling edge when inverted.
// - reading the comparator control register clears the event flag.
// - software writes never change the event flag.
// - compare interrupt asserted one cycle after flag and enable are both set, dropped one cycle after either clears.
// - interrupt enable is read/write, reset to zero, gates the flag.
// - output status bit mirrors the comparator output, zero at reset.
// - route bit drives comparator output onto port a pin seven.
// - power bit turns on comparator, reference and bias; reset clears it.
// - the edge reaches the flag about 250 ns after the output changes.
// - reference register at 2Ch resets 00h; control at 2Dh resets 80h.
`timescale 1ns/100ps
module cmpctl_top (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  output logic             err_o,
  // analog macro
  input  wire logic        cmp_out_i,
  output logic             comparator_power_on_o,
  output logic             hysteresis_select_o,
  output logic             external_reference_select_o,
  output logic             bandgap_reference_select_o,
  output logic [3:0]       reference_level_o,
  // port a pin seven
  output logic             port_a_pin_seven_o,
  output logic             port_a_pin_seven_oe_o,
  // interrupts
  output logic             compare_irq_o,
  output logic             irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [7:0]                       ref_ctrl_r;
  logic                             hyst_r;
  logic                             inv_r;
  logic                             compare_event_flag_r;
  logic                             compare_irq_enable_r;
  logic                             compare_output_state_r;
  logic                             output_pin_route_enable_r;
  logic                             power_r;
  logic [cmpctl_pkg::EVT_W-1:0]     irq_stat_r;
  logic [cmpctl_pkg::EVT_W-1:0]     irq_mask_r;
  logic                             cmp_dly;
  logic                             edge_hit;
  logic                             change_hit;
  logic                             req;
  logic                             wr;
  logic                             rd;
  logic                             hit_ref;
  logic                             hit_cmp;
  logic                             hit_stat;
  logic                             hit_mask;
  logic                             mapped;
  logic [7:0]                       cmp_rd;
  logic [31:0]                      rd_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode: answer one cycle after the request, drop ack the next cycle

  assign req      = cyc_i & stb_i & ~ack_o & ~err_o;
  assign hit_ref  = adr_i == cmpctl_pkg::REF_CTRL_ADDR;
  assign hit_cmp  = adr_i == cmpctl_pkg::CMP_CTRL_ADDR;
  assign hit_stat = adr_i == cmpctl_pkg::IRQ_STAT_ADDR;
  assign hit_mask = adr_i == cmpctl_pkg::IRQ_MASK_ADDR;
  assign mapped   = hit_ref | hit_cmp | hit_stat | hit_mask;
  assign wr       = req & mapped & we_i & sel_i[0];
  assign rd       = req & mapped & ~we_i;

  // the compare output is delayed so the flag sees the edge about 250 ns late
  cmpctl_delay #(
    .DEPTH (cmpctl_pkg::EDGE_DELAY_CYC)
  ) u_delay (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (cmp_out_i),
    .q_o   (cmp_dly)
  );

  cmpctl_edge u_edge (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .level_i   (cmp_dly),
    .falling_i (inv_r),
    .edge_o    (edge_hit),
    .change_o  (change_hit)
  );

  always_comb begin
    cmp_rd                        = 8'h00;
    cmp_rd[cmpctl_pkg::HYST_BIT]  = hyst_r;
    cmp_rd[cmpctl_pkg::INV_BIT]   = inv_r;
    cmp_rd[cmpctl_pkg::FLAG_BIT]  = compare_event_flag_r;
    cmp_rd[cmpctl_pkg::IE_BIT]    = compare_irq_enable_r;
    cmp_rd[cmpctl_pkg::OUT_BIT]   = compare_output_state_r;
    cmp_rd[cmpctl_pkg::ROUTE_BIT] = output_pin_route_enable_r;
    cmp_rd[cmpctl_pkg::PWR_BIT]   = power_r;
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (hit_ref) begin
      rd_nxt[7:0] = ref_ctrl_r & cmpctl_pkg::REF_CTRL_WMASK;
    end else if (hit_cmp) begin
      rd_nxt[7:0] = cmp_rd;
    end else if (hit_stat) begin
      rd_nxt[cmpctl_pkg::EVT_W-1:0] = irq_stat_r;
    end else if (hit_mask) begin
      rd_nxt[cmpctl_pkg::EVT_W-1:0] = irq_mask_r;
    end
  end

  // ack masks req for one cycle, so a held strobe is answered only every other cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req & mapped;
    end
  end

  // unmapped accesses are refused and change no state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_o <= 1'b0;
    end else begin
      err_o <= req & ~mapped;
    end
  end

  // read data stands only in the ack cycle; zero otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else begin
      dat_o <= rd ? rd_nxt : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software storage

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_ctrl_r <= cmpctl_pkg::REF_CTRL_RST;
    end else if (wr && hit_ref) begin
      ref_ctrl_r <= dat_i[7:0] & cmpctl_pkg::REF_CTRL_WMASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hyst_r                    <= cmpctl_pkg::CMP_CTRL_RST[cmpctl_pkg::HYST_BIT];
      inv_r                     <= cmpctl_pkg::CMP_CTRL_RST[cmpctl_pkg::INV_BIT];
      compare_irq_enable_r      <= cmpctl_pkg::CMP_CTRL_RST[cmpctl_pkg::IE_BIT];
      output_pin_route_enable_r <= cmpctl_pkg::CMP_CTRL_RST[cmpctl_pkg::ROUTE_BIT];
      power_r                   <= cmpctl_pkg::CMP_CTRL_RST[cmpctl_pkg::PWR_BIT];
    end else if (wr && hit_cmp) begin
      hyst_r                    <= dat_i[cmpctl_pkg::HYST_BIT];
      inv_r                     <= dat_i[cmpctl_pkg::INV_BIT];
      compare_irq_enable_r      <= dat_i[cmpctl_pkg::IE_BIT];
      output_pin_route_enable_r <= dat_i[cmpctl_pkg::ROUTE_BIT];
      power_r                   <= dat_i[cmpctl_pkg::PWR_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_r <= cmpctl_pkg::IRQ_MASK_RST;
    end else if (wr && hit_mask) begin
      irq_mask_r <= dat_i[cmpctl_pkg::EVT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // hardware state

  // output status bit is hardware-owned; software writes to it are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_output_state_r <= 1'b0;
    end else begin
      compare_output_state_r <= cmp_out_i;
    end
  end

  // the flag ignores writes; a read clears it, but an edge in that cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_event_flag_r <= 1'b0;
    end else if (edge_hit) begin
      compare_event_flag_r <= 1'b1;
    end else if (rd && hit_cmp) begin
      compare_event_flag_r <= 1'b0;
    end
  end

  // write one to clear, a new event in the same cycle stays set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~((wr && hit_stat) ? dat_i[cmpctl_pkg::EVT_W-1:0] : 2'h0))
                    | {change_hit, edge_hit};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, each from a flip-flop

  // compare path: flag gated by its own enable, one cycle late
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_irq_o <= 1'b0;
    end else begin
      compare_irq_o <= compare_event_flag_r & compare_irq_enable_r;
    end
  end

  // generic path: sticky status under the mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

  // analog controls are registered so the macro never sees decode glitches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      comparator_power_on_o <= 1'b0;
    end else begin
      comparator_power_on_o <= power_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hysteresis_select_o <= 1'b1;
    end else begin
      hysteresis_select_o <= hyst_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      external_reference_select_o <= 1'b0;
    end else begin
      external_reference_select_o <= ref_ctrl_r[cmpctl_pkg::EXT_REF_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bandgap_reference_select_o <= 1'b0;
    end else begin
      bandgap_reference_select_o <= ref_ctrl_r[cmpctl_pkg::BANDGAP_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reference_level_o <= 4'h0;
    end else begin
      reference_level_o <= ref_ctrl_r[cmpctl_pkg::LEVEL_MSB:cmpctl_pkg::LEVEL_LSB];
    end
  end

  // pin value takes the raw level, not the delayed one: only the output register's one cycle on the pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_a_pin_seven_o <= 1'b0;
    end else begin
      port_a_pin_seven_o <= output_pin_route_enable_r & cmp_out_i;
    end
  end

  // pin released while the route bit is clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_a_pin_seven_oe_o <= 1'b0;
    end else begin
      port_a_pin_seven_oe_o <= output_pin_route_enable_r;
    end
  end

endmodule : cmpctl_top

// file: verilog/cmpctl_pkg.sv
/*
 * constants for the comparator control and interrupt block: register
 * offsets, field positions, reset values and timing counts.
 * assumes a 32-bit classic wishbone bus; each register takes one word.
 */
package cmpctl_pkg;

  // printed offsets are register indices; byte address is four times the index
  localparam logic [7:0]  REF_CTRL_IDX    = 8'h2C;
  localparam logic [7:0]  CMP_CTRL_IDX    = 8'h2D;
  localparam logic [7:0]  IRQ_STAT_IDX    = 8'h30;
  localparam logic [7:0]  IRQ_MASK_IDX    = 8'h31;
  localparam int          ADDR_W          = 10;
  localparam logic [9:0]  REF_CTRL_ADDR   = {REF_CTRL_IDX, 2'b00};
  localparam logic [9:0]  CMP_CTRL_ADDR   = {CMP_CTRL_IDX, 2'b00};
  localparam logic [9:0]  IRQ_STAT_ADDR   = {IRQ_STAT_IDX, 2'b00};
  localparam logic [9:0]  IRQ_MASK_ADDR   = {IRQ_MASK_IDX, 2'b00};

  // reference_select_control fields
  localparam int          EXT_REF_BIT     = 7;
  localparam int          BANDGAP_BIT     = 6;
  localparam int          LEVEL_MSB       = 5;
  localparam int          LEVEL_LSB       = 2;
  localparam logic [7:0]  REF_CTRL_RST    = 8'h00;
  localparam logic [7:0]  REF_CTRL_WMASK  = 8'hFC;

  // comparator_control_status fields
  localparam int          HYST_BIT        = 7;
  localparam int          INV_BIT         = 5;
  localparam int          FLAG_BIT        = 4;
  localparam int          IE_BIT          = 3;
  localparam int          OUT_BIT         = 2;
  localparam int          ROUTE_BIT       = 1;
  localparam int          PWR_BIT         = 0;
  localparam logic [7:0]  CMP_CTRL_RST    = 8'h80;

  // interrupt status: bit 0 compare event, bit 1 any output change
  localparam int          EVT_W           = 2;
  localparam logic [1:0]  IRQ_MASK_RST    = 2'h0;

  // timing
  localparam int          CLK_PERIOD_NS   = 40;
  localparam int          EDGE_DELAY_NS   = 250;
  localparam int          EDGE_DELAY_CYC  = (EDGE_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 :
                                            EDGE_DELAY_NS / CLK_PERIOD_NS;

endpackage : cmpctl_pkg

// file: verilog/cmpctl_delay.sv
/*
 * fixed-length shift delay for the comparator output level.
 * assumes the input is already synchronous to clk_i.
 */
`timescale 1ns/100ps
module cmpctl_delay #(
  parameter int DEPTH = 6
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // level
  input  wire logic d_i,
  output logic      q_o
);

  logic [DEPTH-1:0] pipe_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pipe_r <= '0;
    end else begin
      pipe_r <= {pipe_r[DEPTH-2:0], d_i};
    end
  end

  assign q_o = pipe_r[DEPTH-1];

endmodule : cmpctl_delay

// file: verilog/cmpctl_edge.sv
/*
 * edge detector with selectable polarity, one-cycle pulse out.
 * assumes a delayed, synchronous level at its input.
 */
`timescale 1ns/100ps
module cmpctl_edge (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // level and selection
  input  wire logic level_i,
  input  wire logic falling_i,
  // pulses
  output logic      edge_o,
  output logic      change_o
);

  logic prev_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= level_i;
    end
  end

  assign change_o = level_i ^ prev_r;
  assign edge_o   = falling_i ? (prev_r & ~level_i) : (~prev_r & level_i);

endmodule : cmpctl_edge

// file: tb/cmpctl_properties.sv
/* concurrent checks on cmpctl_top; sees only the top ports, bound below */
`timescale 1ns/100ps
module cmpctl_properties (
  // clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [9:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        err_o,
  // macro, pin and interrupt side
  input wire logic        cmp_out_i,
  input wire logic        comparator_power_on_o,
  input wire logic        hysteresis_select_o,
  input wire logic        port_a_pin_seven_o,
  input wire logic        port_a_pin_seven_oe_o,
  input wire logic        compare_irq_o
);
  logic pwr_r, ie_r, route_r;
  wire logic req = cyc_i && stb_i && !ack_o && !err_o;
  wire logic hit = adr_i inside {cmpctl_pkg::REF_CTRL_ADDR, cmpctl_pkg::CMP_CTRL_ADDR,
                                 cmpctl_pkg::IRQ_STAT_ADDR, cmpctl_pkg::IRQ_MASK_ADDR};
  wire logic ctl = adr_i == cmpctl_pkg::CMP_CTRL_ADDR;
  // shadow taken at the ack edge; checks wait three steady cycles for slack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {pwr_r, ie_r, route_r} <= 3'h0;
    end else if (ack_o && we_i && sel_i[0] && ctl) begin
      {pwr_r, ie_r, route_r} <= {dat_i[0], dat_i[3], dat_i[1]};
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence steady_s;
    $stable(cmp_out_i)[*3];
  endsequence
  req_answer_a: assert property (req && hit |=> ack_o && !err_o)
    else $error("mapped access not acknowledged");
  unmapped_err_a: assert property (req && !hit |=> err_o && !ack_o)
    else $error("unmapped access not refused");
  spare_bits_a: assert property (ack_o && !we_i && ctl |-> dat_o[31:8] == 24'h0 && !dat_o[6])
    else $error("unused bits read nonzero");
  reset_value_a: assert property ($past(rst_i) |-> hysteresis_select_o && !comparator_power_on_o)
    else $error("wrong outputs after reset");
  power_follow_a: assert property ($stable(pwr_r)[*3] |-> comparator_power_on_o == pwr_r)
    else $error("power output differs from written bit");
  route_enable_a: assert property ($stable(route_r)[*3] |-> port_a_pin_seven_oe_o == route_r)
    else $error("pin enable differs from route bit");
  pin_off_a: assert property ((!route_r)[*3] |-> !port_a_pin_seven_o)
    else $error("pin driven while not routed");
  irq_gate_a: assert property ((!ie_r)[*3] |-> !compare_irq_o)
    else $error("compare interrupt while disabled");
  out_mirror_a: assert property (steady_s ##0 (ack_o && !we_i && ctl) |-> dat_o[2] == cmp_out_i)
    else $error("output status bit not mirrored");
  cover property (err_o);
  cover property ($rose(compare_irq_o));
  cover property (port_a_pin_seven_o);
endmodule : cmpctl_properties

bind cmpctl_top cmpctl_properties u_cmpctl_properties (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
  .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .err_o, .cmp_out_i, .comparator_power_on_o,
  .hysteresis_select_o, .port_a_pin_seven_o, .port_a_pin_seven_oe_o, .compare_irq_o);

// file: tb/cmpctl_analog_model.sv
/* behavioural comparator macro; assumes the bench sets the wanted level */
`timescale 1ns/100ps
module cmpctl_analog_model (
  // clock
  input  wire logic clk_i,
  // power from the block, target from the bench
  input  wire logic power_on_i,
  input  wire logic target_i,
  // comparator output
  output logic      cmp_out_o
);
  // powered down the output sits low, so a power drop looks like a fall
  always_ff @(posedge clk_i) begin
    cmp_out_o <= power_on_i & target_i;
  end
endmodule : cmpctl_analog_model

// file: tb/cmpctl_top_bench.sv
/* self-checking bench for cmpctl_top with an integer register model */
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module cmpctl_top_bench;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic        drive_v = 1'b0, last_err, ack_o, err_o, cmp_out_i, comparator_power_on_o;
  logic        hysteresis_select_o, external_reference_select_o, bandgap_reference_select_o;
  logic        port_a_pin_seven_o, port_a_pin_seven_oe_o, compare_irq_o, irq_o;
  logic [3:0]  sel_i = 4'h0, reference_level_o;
  logic [9:0]  adr_i = 10'h000;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic [9:0]  adrs [4] = '{cmpctl_pkg::REF_CTRL_ADDR, cmpctl_pkg::CMP_CTRL_ADDR,
                            cmpctl_pkg::IRQ_STAT_ADDR, cmpctl_pkg::IRQ_MASK_ADDR};
  int          m [4] = '{0, 8'h80, 0, 0}, flag = 0, lvl = 0, seed = 32'hFDCF;
  int          n_errors = 0, total_checks = 0;
  cmpctl_top u_cmpctl_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .err_o, .cmp_out_i, .comparator_power_on_o, .hysteresis_select_o,
    .external_reference_select_o, .bandgap_reference_select_o, .reference_level_o,
    .port_a_pin_seven_o, .port_a_pin_seven_oe_o, .compare_irq_o, .irq_o);
  cmpctl_analog_model u_cmpctl_analog_model (.clk_i, .power_on_i(comparator_power_on_o),
    .target_i(drive_v), .cmp_out_o(cmp_out_i));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic wb(input logic w, input logic [9:0] a, input int d, input logic [3:0] s,
                    output logic [31:0] q);
    int n;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, w, a, s, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (!(ack_o || err_o) && n < 20);
    if (n >= 20) n_errors++;
    q = dat_o;
    last_err = err_o;
    {cyc_i, stb_i} <= 2'h0;
  endtask : wb
  task automatic wr(input int k, input int d);
    logic [31:0] q;
    wb(1'b1, adrs[k], d, 4'hF, q);
    case (k)
      0: m[0] = d & 8'hFC;
      1: m[1] = d & 8'hAB;
      2: m[2] &= ~d;
      default: m[3] = d & 3;
    endcase
  endtask : wr
  task automatic rd(input int k);
    logic [31:0] q;
    int e;
    e = (k == 1) ? (m[1] | flag << 4 | lvl << 2) : m[k];
    wb(1'b0, adrs[k], 0, 4'hF, q);
    if (k == 1) flag = 0;
    `CHK("read data", e, q)
  endtask : rd
  task automatic chk_out;
    repeat (3) @(posedge clk_i);
    `CHK("compare irq", flag & m[1][3], compare_irq_o)
    `CHK("masked irq", |(m[2] & m[3]), irq_o)
    `CHK("pin", lvl & m[1][1], port_a_pin_seven_o)
    `CHK("pin enable", m[1][1], port_a_pin_seven_oe_o)
    `CHK("power", m[1][0], comparator_power_on_o)
    `CHK("hysteresis", m[1][7], hysteresis_select_o)
  endtask : chk_out
  // an edge must not reach the interrupt before the settling delay
  task automatic set_lvl(input int v);
    int pre;
    pre = flag & m[1][3];
    @(posedge clk_i);
    drive_v <= v[0];
    if (v != lvl) begin
      m[2] |= 2;
      if (v != m[1][5]) begin
        flag = 1;
        m[2] |= 1;
      end
    end
    lvl = v;
    repeat (5) @(posedge clk_i);
    `CHK("early irq", pre, compare_irq_o)
    repeat (7) @(posedge clk_i);
    chk_out();
  endtask : set_lvl
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q;
    int r;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(0);
    rd(1);
    chk_out();
    r = $random(seed);
    wr(0, r & 8'hFF);
    rd(0);
    `CHK("ref level", m[0][5:2], reference_level_o)
    `CHK("ref source", m[0][7:6], {external_reference_select_o, bandgap_reference_select_o})
    wb(1'b0, 10'h3FC, 0, 4'hF, q);
    `CHK("unmapped", 1'b1, last_err)
    wb(1'b1, adrs[1], 8'h0B, 4'hE, q);
    rd(1);
    for (int i = 0; i < 2; i++) begin
      wr(1, r & 8'h80 | 8'h03 | i << 5);
      set_lvl(1);
      rd(1);
      rd(1);
      set_lvl(0);
      rd(1);
    end
    wr(1, 8'h1B);
    rd(1);
    wr(3, 3);
    set_lvl(1);
    rd(1);
    chk_out();
    wr(2, 1);
    chk_out();
    wr(2, 2);
    chk_out();
    wr(1, 8'h03);
    set_lvl(0);
    set_lvl(1);
    rd(2);
    rd(3);
    tally_and_finish();
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    n_errors++;
    tally_and_finish();
  end
endmodule : cmpctl_top_bench
